// ==== hw/eeprom_pkg.sv ====
/*
 * shared constants and types of the serial eeprom write slave.
 * assumes nothing of its surroundings; every file names items as eeprom_pkg::name.
 */
package eeprom_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_COUNT = 64;
    localparam int OFS_W = 4;
    localparam int PAGE_W = 6;

    // device address byte fields
    localparam int RW_BIT = 0;
    localparam int A8_BIT = 1;
    localparam int A9_BIT = 2;
    localparam int HWSEL_BIT = 3;
    localparam int TYPE_LSB = 4;
    localparam int TYPE_MSB = 7;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [4:0] COMMIT_END = 5'h10;

    typedef enum logic [1:0] {
        BYTE_DEV,
        BYTE_WADDR,
        BYTE_DATA
    } byte_kind_t;

endpackage

// ==== hw/eeprom_write_ctrl.sv ====
/*
 * two-wire eeprom slave: device and word addressing, byte and page write,
 * self-timed programming, acknowledge polling and write protect.
 * assumes scl, sda, address select and write protect are asynchronous pins;
 * the sda pad is open drain, pulled low while sda_oe_o is high.
 */
// Notes on behaviour
// - array is 64 pages of 16 bytes
// - top nibble must hold device type identifier
// - bit 3 must equal address select input
// - bits 2 and 1 are address bits 9,8
// - bit 0 high reads, low writes
// - mismatch gets no ack, wait next start
// - word address byte gives low eight bits
// - byte write acked, programming starts at stop
// - bus ignored while programming runs
// - page write keeps bits 9 to 4
// - up to fifteen more bytes, each acked
// - only low four address bits increment
// - polling acked only after programming ends
// - write protect high protects whole array
// - write protect sampled at stop only
// - protected write acked, no programming cycle
// - start and stop are sda edges, scl high
// - msb first, ninth clock carries acknowledge
// - latch on scl rise, drive after fall
// - stop gives standby unless programming begins
`timescale 1ns/1ns
`default_nettype none

module eeprom_write_ctrl #(
    parameter logic [3:0] DEV_TYPE_ID = 4'h6, // arbitrary value
    parameter int unsigned PROG_CYCLES = 1000
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic hw_address_select_i,
    input wire logic write_protect_i,
    input wire logic [eeprom_pkg::ADDR_W-1:0] peek_addr_i,
    output logic [eeprom_pkg::DATA_W-1:0] peek_data_o,
    output logic prog_busy_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_IGNORE,
        ST_PROG
    } state_t;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [3:0] pin_m_r;
    logic [3:0] pin_s_r;
    logic scl_q_r;
    logic sda_q_r;
    logic scl_s;
    logic sda_s;
    logic hwsel_s;
    logic wp_s;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_m_r <= 4'h3;
            pin_s_r <= 4'h3;
        end else begin
            pin_m_r <= {write_protect_i, hw_address_select_i, sda_i, scl_i};
            pin_s_r <= pin_m_r;
        end
    end
    assign scl_s = pin_s_r[0];
    assign sda_s = pin_s_r[1];
    assign hwsel_s = pin_s_r[2];
    assign wp_s = pin_s_r[3];
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // ---------------------------------------------------------------
    // bus events
    // ---------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_s && !scl_q_r;
    assign scl_fall = !scl_s && scl_q_r;
    assign start_det = scl_s && scl_q_r && sda_q_r && !sda_s;
    assign stop_det = scl_s && scl_q_r && !sda_q_r && sda_s;

    // ---------------------------------------------------------------
    // byte receiver and decode
    // ---------------------------------------------------------------
    state_t state_r;
    eeprom_pkg::byte_kind_t kind_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [eeprom_pkg::ADDR_W-1:0] addr_r;
    logic read_mode_r;
    logic sda_oe_r;
    logic [eeprom_pkg::PAGE_BYTES-1:0] valid_r;
    logic [4:0] commit_idx_r;
    logic timer_busy;
    logic byte_done;
    logic dev_match;
    logic accept;
    logic data_accept;
    logic prog_go;
    logic bus_live;
    assign bus_live = (state_r != ST_PROG);
    assign byte_done = (state_r == ST_RX) && scl_fall && (bit_cnt_r == eeprom_pkg::BITS_PER_BYTE);
    assign dev_match = (shift_r[eeprom_pkg::TYPE_MSB:eeprom_pkg::TYPE_LSB] == DEV_TYPE_ID)
        && (shift_r[eeprom_pkg::HWSEL_BIT] == hwsel_s);
    assign accept = (kind_r != eeprom_pkg::BYTE_DEV) || dev_match;
    assign data_accept = byte_done && (kind_r == eeprom_pkg::BYTE_DATA);
    // write protect is looked at only here, at the stop
    assign prog_go = ((state_r == ST_RX) || (state_r == ST_ACK)) && (|valid_r) && !wp_s;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (bus_live && start_det) begin
            bit_cnt_r <= 4'h0;
        end else if ((state_r == ST_RX) && scl_rise && (bit_cnt_r != eeprom_pkg::BITS_PER_BYTE)) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if ((state_r == ST_ACK) && scl_fall) begin
            bit_cnt_r <= 4'h0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            kind_r <= eeprom_pkg::BYTE_DEV;
            read_mode_r <= 1'b0;
        end else if (bus_live && start_det) begin
            kind_r <= eeprom_pkg::BYTE_DEV;
            read_mode_r <= 1'b0;
        end else if (byte_done && accept) begin
            case (kind_r)
                eeprom_pkg::BYTE_DEV: begin
                    kind_r <= eeprom_pkg::BYTE_WADDR;
                    read_mode_r <= shift_r[eeprom_pkg::RW_BIT];
                end
                default: begin
                    kind_r <= eeprom_pkg::BYTE_DATA;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            addr_r <= 10'h000;
        end else if (byte_done && accept) begin
            case (kind_r)
                eeprom_pkg::BYTE_DEV: begin
                    if (!shift_r[eeprom_pkg::RW_BIT]) begin
                        addr_r[9] <= shift_r[eeprom_pkg::A9_BIT];
                        addr_r[8] <= shift_r[eeprom_pkg::A8_BIT];
                    end
                end
                eeprom_pkg::BYTE_WADDR: begin
                    addr_r[7:0] <= shift_r;
                end
                default: begin
                    // page bits held, offset wraps inside the page
                    addr_r[eeprom_pkg::OFS_W-1:0] <= addr_r[eeprom_pkg::OFS_W-1:0] + 4'h1;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // page buffer, one entry per byte of the page
    // ---------------------------------------------------------------
    logic [7:0] page_buf_r [eeprom_pkg::PAGE_BYTES];
    for (genvar e = 0; e < eeprom_pkg::PAGE_BYTES; e++) begin : g_page
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                page_buf_r[e] <= 8'h00;
                valid_r[e] <= 1'b0;
            end else if (bus_live && start_det) begin
                valid_r[e] <= 1'b0;
            end else if ((state_r == ST_PROG) && (commit_idx_r == eeprom_pkg::COMMIT_END)) begin
                valid_r[e] <= 1'b0;
            end else if (data_accept && (addr_r[eeprom_pkg::OFS_W-1:0] == 4'(e))) begin
                page_buf_r[e] <= shift_r;
                valid_r[e] <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_PROG: begin
                    // bus fully ignored until the cycle ends
                    if ((commit_idx_r == eeprom_pkg::COMMIT_END) && !timer_busy) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_RX: begin
                    if (start_det) begin
                        state_r <= ST_RX;
                    end else if (stop_det) begin
                        state_r <= prog_go ? ST_PROG : ST_IDLE;
                    end else if (byte_done) begin
                        state_r <= accept ? ST_ACK : ST_IGNORE;
                    end
                end
                ST_ACK: begin
                    if (start_det) begin
                        state_r <= ST_RX;
                    end else if (stop_det) begin
                        state_r <= prog_go ? ST_PROG : ST_IDLE;
                    end else if (scl_fall) begin
                        state_r <= read_mode_r ? ST_IGNORE : ST_RX;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    if (start_det) begin
                        state_r <= ST_RX;
                    end else if (stop_det) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // acknowledge drive: set after the eighth fall, released after the ninth
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sda_oe_r <= 1'b0;
        end else if (!bus_live || start_det || stop_det) begin
            sda_oe_r <= 1'b0;
        end else if (byte_done) begin
            sda_oe_r <= accept;
        end else if ((state_r == ST_ACK) && scl_fall) begin
            sda_oe_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // programming: copy loaded bytes into the array while the timer runs out
    // ---------------------------------------------------------------
    logic prog_start;
    logic [eeprom_pkg::OFS_W-1:0] commit_ofs;
    assign prog_start = (state_r != ST_PROG) && stop_det && prog_go;
    assign commit_ofs = commit_idx_r[eeprom_pkg::OFS_W-1:0];
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            commit_idx_r <= 5'h00;
        end else if (prog_start) begin
            commit_idx_r <= 5'h00;
        end else if ((state_r == ST_PROG) && (commit_idx_r != eeprom_pkg::COMMIT_END)) begin
            commit_idx_r <= commit_idx_r + 5'h01;
        end
    end
    prog_timer #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(prog_start),
        .busy_o(timer_busy)
    );
    mem_if memif ();
    assign memif.wr_en = (state_r == ST_PROG) && (commit_idx_r != eeprom_pkg::COMMIT_END) && valid_r[commit_ofs];
    assign memif.wr_addr = {addr_r[eeprom_pkg::ADDR_W-1:eeprom_pkg::OFS_W], commit_ofs};
    assign memif.wr_data = page_buf_r[commit_ofs];
    assign memif.rd_addr = peek_addr_i;
    nv_array #(
        .DEPTH(eeprom_pkg::PAGE_COUNT * eeprom_pkg::PAGE_BYTES)
    ) u_array (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .mem(memif.array)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prog_busy_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            prog_busy_o <= prog_start || ((state_r == ST_PROG) && !((commit_idx_r == eeprom_pkg::COMMIT_END)
                && !timer_busy));
            sda_o <= 1'b0;
        end
    end

    assign sda_oe_o = sda_oe_r;
    assign peek_data_o = memif.rd_data;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    chk_nack_mismatch: assert property (
        (byte_done && kind_r == eeprom_pkg::BYTE_DEV && !dev_match && !start_det && !stop_det)
        |=> ((state_r == ST_IGNORE) && !sda_oe_r) [*2])
        else $error("mismatched address byte was acknowledged");
    chk_ack_data: assert property (
        (data_accept && !start_det && !stop_det) |=> sda_oe_r && (state_r == ST_ACK))
        else $error("data byte not acknowledged");
    chk_prog_start: assert property (
        prog_start |=> (state_r == ST_PROG) && prog_busy_o ##1 timer_busy)
        else $error("programming did not start at stop");
    chk_wp_block: assert property (
        ((state_r == ST_RX || state_r == ST_ACK) && stop_det && wp_s) |=> (state_r == ST_IDLE))
        else $error("protected write entered programming");
    chk_no_ack_prog: assert property (
        (state_r == ST_PROG) |-> !sda_oe_r && (!memif.wr_en || (commit_idx_r < eeprom_pkg::COMMIT_END)))
        else $error("bus answered during programming");
    chk_poll_hold: assert property (
        ((state_r == ST_PROG) && timer_busy) |=> (state_r == ST_PROG))
        else $error("programming left before the timer ended");
    chk_page_wrap: assert property (
        data_accept |=> (addr_r[9:4] == $past(addr_r[9:4]))
            && (addr_r[3:0] == $past(addr_r[3:0]) + 4'h1))
        else $error("page address not wrapped correctly");
    chk_hi_addr: assert property (
        (byte_done && kind_r == eeprom_pkg::BYTE_DEV && dev_match && !shift_r[eeprom_pkg::RW_BIT])
        |=> addr_r[9:8] == $past(shift_r[eeprom_pkg::A9_BIT:eeprom_pkg::A8_BIT]))
        else $error("high address bits not taken from address byte");
    chk_latch_rise: assert property (
        $changed(shift_r) |-> $past(scl_rise))
        else $error("data latched off a rising scl edge");
    chk_sda_fall: assert property (
        $rose(sda_oe_r) |-> $past(scl_fall))
        else $error("sda driven outside a falling scl edge");
    chk_start_det: assert property (
        (start_det && bus_live) |=> (state_r == ST_RX) && (bit_cnt_r == 4'h0))
        else $error("start not recognised");
endmodule

`default_nettype wire

// ==== hw/mem_if.sv ====
/*
 * write and read port between the bus controller and the nonvolatile array.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface mem_if;
    logic wr_en;
    logic [eeprom_pkg::ADDR_W-1:0] wr_addr;
    logic [eeprom_pkg::DATA_W-1:0] wr_data;
    logic [eeprom_pkg::ADDR_W-1:0] rd_addr;
    logic [eeprom_pkg::DATA_W-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport array (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// ==== hw/nv_array.sv ====
/*
 * the byte array: one write port, one read port with registered data.
 * assumes a single clock; contents are undefined until written.
 */
`timescale 1ns/1ns
`default_nettype none

module nv_array #(
    parameter int DEPTH = eeprom_pkg::PAGE_COUNT * eeprom_pkg::PAGE_BYTES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    mem_if.array mem
);
    logic [eeprom_pkg::DATA_W-1:0] cells [DEPTH];

    always_ff @(posedge clk_i) begin
        if (mem.wr_en) begin
            cells[mem.wr_addr] <= mem.wr_data;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem.rd_data <= 8'h00;
        end else begin
            mem.rd_data <= cells[mem.rd_addr];
        end
    end
endmodule

`default_nettype wire

// ==== hw/prog_timer.sv ====
/*
 * self-timed programming cycle: a down counter loaded by a start pulse.
 * assumes start_i is a one-cycle pulse on clk_i.
 */
`timescale 1ns/1ns
`default_nettype none

module prog_timer #(
    parameter int unsigned PROG_CYCLES = 1000
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    output logic busy_o
);
    logic [31:0] count_r;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_r <= 32'h0;
        end else if (start_i) begin
            count_r <= 32'(PROG_CYCLES);
        end else if (count_r != 32'h0) begin
            count_r <= count_r - 32'h1;
        end
    end

    assign busy_o = (count_r != 32'h0);
endmodule

`default_nettype wire

// ==== testbench/i2c_master_model.sv ====
/*
 * two-wire bus master model: start, stop and byte transfer tasks.
 * assumes sda_i is the resolved wire and the pull-up gives high when released.
 */
`timescale 1ns/1ns
`default_nettype none

module i2c_master_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // ----------------------------------------
    // bus phases, all moves on falling clk
    // ----------------------------------------
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // sda falls while scl high, scl stands still outside frames
    task automatic start();
        idle(1);
        sda_low_o = 1'b0;
        idle(2);
        scl_o = 1'b1;
        idle(3);
        sda_low_o = 1'b1;
        idle(3);
        scl_o = 1'b0;
        idle(3);
    endtask

    task automatic stop();
        sda_low_o = 1'b1;
        idle(3);
        scl_o = 1'b1;
        idle(3);
        sda_low_o = 1'b0;
        idle(4);
    endtask

    // msb first, then a released ninth clock for the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low_o = ~b[i];
            idle(3);
            scl_o = 1'b1;
            idle(2);
            scl_o = 1'b0;
            idle(3);
        end
        sda_low_o = 1'b0;
        idle(3);
        scl_o = 1'b1;
        idle(1);
        ack = sda_i;
        idle(1);
        scl_o = 1'b0;
        idle(3);
    endtask
endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
/*
 * self-checking bench of the eeprom write slave.
 * assumes the master model in i2c_master_model.sv and a shortened programming time.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    localparam logic [3:0] TYPE_ID = 4'h6; // arbitrary value
    localparam int PROG = 200;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hwsel = 1'b0;
    logic wp = 1'b0;
    logic [9:0] peek_addr = 10'h000;
    logic [7:0] peek_data;
    logic sda_o, sda_oe, busy, scl, m_low, ack;
    logic [3:0] id;
    logic [9:0] a;
    wire logic sda = !(m_low || (sda_oe && !sda_o));
    int err_count = 0;
    int total_checks = 0;
    int busy_len = 0;
    logic [7:0] exp_mem [1024];

    always #10 clk_i = ~clk_i;

    // length of the programming cycle as seen on the busy output
    always @(negedge clk_i) begin
        if (busy === 1'b1) busy_len++;
    end

    i2c_master_model M (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

    eeprom_write_ctrl #(.DEV_TYPE_ID(TYPE_ID), .PROG_CYCLES(PROG)) DUT (
        .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .hw_address_select_i(hwsel), .write_protect_i(wp),
        .peek_addr_i(peek_addr), .peek_data_o(peek_data), .prog_busy_o(busy));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic [7:0] dev_byte(logic [3:0] t, logic s, logic [9:0] ad, logic rw);
        return {t, s, ad[9:8], rw};
    endfunction

    function automatic logic [9:0] slot(logic [9:0] ad, int i);
        return {ad[9:4], ad[3:0] + i[3:0]};
    endfunction

    task automatic poll(input logic rw, output logic k);
        M.start();
        M.send_byte(dev_byte(TYPE_ID, hwsel, 10'h000, rw), k);
        M.stop();
    endtask

    task automatic write_cmd(input logic [9:0] ad, input int n);
        logic [7:0] d;
        busy_len = 0;
        M.start();
        M.send_byte(dev_byte(TYPE_ID, hwsel, ad, 1'b0), ack);
        check(ack, 1'b0, "device ack");
        M.send_byte(ad[7:0], ack);
        check(ack, 1'b0, "word ack");
        for (int i = 0; i < n; i++) begin
            d = $urandom;
            M.send_byte(d, ack);
            check(ack, 1'b0, "data ack");
            if (!wp) exp_mem[slot(ad, i)] = d;
        end
        M.stop();
    endtask

    task automatic finish_write(input logic exp_busy);
        int k;
        k = 0;
        while (busy !== 1'b1 && k < 20) begin
            @(negedge clk_i);
            k++;
        end
        check(busy, exp_busy, "busy after stop");
        if (exp_busy) begin
            k = 0;
            poll(1'b0, ack);
            check(ack, 1'b1, "poll while busy");
            check(busy, 1'b1, "busy after ignored poll");
            while (busy === 1'b1 && k < 400) begin
                @(negedge clk_i);
                k++;
            end
            check(busy_len >= PROG && busy_len <= PROG + 40, 1'b1, "program time");
        end else begin
            check(busy_len, 0, "protected write busy");
        end
        poll(1'b0, ack);
        check(ack, 1'b0, "poll when ready");
    endtask

    task automatic verify(input logic [9:0] ad);
        for (int i = 0; i < 16; i++) begin
            peek_addr = slot(ad, i);
            repeat (2) @(negedge clk_i);
            if (!$isunknown(exp_mem[peek_addr])) check(peek_data, exp_mem[peek_addr], "array byte");
        end
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        void'($urandom(32'h65770ee2));
        repeat (16) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 6; i++) begin
            hwsel = $urandom;
            id = (i < 3) ? TYPE_ID ^ (4'h2 << i) : TYPE_ID;
            M.start();
            M.send_byte(dev_byte(id, (i < 3) ? hwsel : ~hwsel, 10'h3ff, 1'b0), ack);
            check(ack, 1'b1, "foreign address");
            M.send_byte(8'h00, ack);
            check(ack, 1'b1, "ignored byte");
            M.stop();
        end
        $display("test address mismatch done");
        for (int i = 0; i < 2; i++) begin
            hwsel = i[0];
            poll(1'b1, ack);
            check(ack, 1'b0, "read address");
        end
        $display("test read address done");
        for (int i = 0; i < 3; i++) begin
            hwsel = i[0];
            a = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'($urandom);
            write_cmd(a, 1);
            finish_write(1'b1);
            verify(a);
        end
        $display("test byte write done");
        a = {6'($urandom), 4'h5};
        write_cmd(a, 16);
        finish_write(1'b1);
        verify(a);
        a = 10'($urandom);
        write_cmd(a, 17);
        finish_write(1'b1);
        verify(a);
        $display("test page write done");
        wp = 1'b1;
        write_cmd(a, 4);
        finish_write(1'b0);
        verify(a);
        wp = 1'b0;
        write_cmd(a, 2);
        repeat (8) @(negedge clk_i);
        wp = 1'b1;
        finish_write(1'b1);
        verify(a);
        wp = 1'b0;
        $display("test write protect done");
        print_verdict();
    end

    initial begin
        #1000000;
        err_count++;
        print_verdict();
    end
endmodule

`default_nettype wire
